// file: rtl/stpc_pkg.sv
// Summary of operation
// - power kill low forces manual powerdown
// - both force inputs high: always active
// - thirty idle seconds cause automatic powerdown
// - powerdown puts transmitter outputs high impedance
// - receiver outputs always drive, never tristate
// - charge pump off in down state, on in wake and active
// - transmission resumes within 100 us wake
// - kill release alone does not wake
// - keep awake fall holds thirty seconds up
// - validity flag on force inputs powers device
// - transmitter output is inverted logic input
// - receiver output is inverted line input
// - data path carries at least 250 kbit/s
// - edge counts only on threshold crossing
// - validity flag rises 1 us after valid level
// - validity flag falls after 30 us invalid
// - timer stays expired once powered down
`default_nettype none
package stpc_pkg;
   localparam int unsigned CLK_MHZ        = 250;
   localparam int unsigned IDLE_SEC       = 30;
   localparam int unsigned WAKE_US        = 100;
   localparam int unsigned VALID_RISE_US  = 1;
   localparam int unsigned VALID_FALL_US  = 30;
   // cycle counts; all full-speed logic, so 250 kbit/s is trivially met
   localparam longint unsigned IDLE_CYC   = longint'(IDLE_SEC) * 64'hF4240 * CLK_MHZ;
   localparam int unsigned WAKE_CYC       = WAKE_US * CLK_MHZ;
   localparam int unsigned VALID_RISE_CYC = VALID_RISE_US * CLK_MHZ;
   localparam int unsigned VALID_FALL_CYC = VALID_FALL_US * CLK_MHZ;
   localparam logic        RST_VALID      = 1'b0;
   typedef enum logic [1:0] {
      STPC_DOWN  = 2'b00,
      STPC_WAKE  = 2'b01,
      STPC_ACTIVE = 2'b10
   } stpc_state_t;
endpackage
`default_nettype wire

// file: rtl/stpc_valid_det.sv
`timescale 1ns/1ns
`default_nettype none
module stpc_valid_det #(
   parameter int unsigned NRX       = 2,
   parameter int unsigned RISE_CYC  = stpc_pkg::VALID_RISE_CYC,
   parameter int unsigned FALL_CYC  = stpc_pkg::VALID_FALL_CYC
) (
   input  wire logic           sys_clk,
   input  wire logic           reset_n,
   input  wire logic [NRX-1:0] rx_level_valid,
   output logic                line_valid
);
   localparam int W = $clog2(FALL_CYC + 2);
   logic [W-1:0] cnt;
   logic [W-1:0] next_cnt;
   logic         next_valid;
   logic         any_valid;

   // flag filters in both directions; counter runs while input and flag disagree, clears when they agree
   always_comb begin
      any_valid  = |rx_level_valid;
      next_cnt   = '0;
      next_valid = line_valid;
      if (any_valid != line_valid) begin
         next_cnt = cnt + W'(1);
         if (any_valid && cnt >= W'(RISE_CYC - 1)) begin
            next_valid = 1'b1;
            next_cnt   = '0;
         end else if (!any_valid && cnt >= W'(FALL_CYC)) begin
            next_valid = 1'b0;
            next_cnt   = '0;
         end
      end
   end

   always_ff @(posedge sys_clk) begin
      if (!reset_n) begin
         cnt        <= '0;
         line_valid <= stpc_pkg::RST_VALID;
      end else begin
         cnt        <= next_cnt;
         line_valid <= next_valid;
      end
   end

   AST_VALID_RISE: assert property (@(posedge sys_clk) disable iff (!reset_n)
      (!line_valid && (&rx_level_valid || |rx_level_valid))[*1] ##0
      $rose(|rx_level_valid) |-> ##[1:300] (line_valid || !(|rx_level_valid)))
      else $error("validity flag slow to rise");
   AST_VALID_HOLD: assert property (@(posedge sys_clk) disable iff (!reset_n)
      $fell(line_valid) |-> $past(cnt) >= W'(FALL_CYC))
      else $error("validity flag fell early");
endmodule
`default_nettype wire

// file: rtl/stpc_top.sv
`timescale 1ns/1ns
`default_nettype none
module stpc_top #(
   parameter int unsigned    NTX       = 2,
   parameter int unsigned    NRX       = 2,
   parameter longint unsigned IDLE_CYC = stpc_pkg::IDLE_CYC,
   parameter int unsigned    WAKE_CYC  = stpc_pkg::WAKE_CYC
) (
   input  wire logic           sys_clk,
   input  wire logic           reset_n,
   input  wire logic           keep_awake_input,
   input  wire logic           power_kill_input,
   input  wire logic [NTX-1:0] tx_logic_in,
   output logic      [NTX-1:0] tx_line_out,
   output logic      [NTX-1:0] tx_line_oe,
   input  wire logic [NRX-1:0] rx_line_in,
   input  wire logic [NRX-1:0] rx_level_valid,
   output logic      [NRX-1:0] rx_logic_out,
   output logic      [NRX-1:0] rx_logic_oe,
   output logic                line_valid,
   output logic                charge_pump_en,
   output logic                powered_down
);
   localparam int IW = $clog2(IDLE_CYC + 1);
   localparam int WW = $clog2(WAKE_CYC + 1);

   stpc_pkg::stpc_state_t state;
   stpc_pkg::stpc_state_t next_state;
   logic [IW-1:0] idle_cnt;
   logic [IW-1:0] next_idle_cnt;
   logic [WW-1:0] wake_cnt;
   logic [WW-1:0] next_wake_cnt;
   logic          timer_done;
   logic          next_timer_done;
   logic [NTX-1:0] tx_prev;
   logic [NRX-1:0] rx_prev;
   logic          keep_prev;
   logic          activity;
   logic          keep_fall;
   logic          keep_rise;
   logic          both_high;
   logic          up_req;

   stpc_valid_det #(.NRX(NRX)) u_valid (
      .sys_clk        (sys_clk),
      .reset_n        (reset_n),
      .rx_level_valid (rx_level_valid),
      .line_valid     (line_valid)
   );

   // inputs are digital already, so any level change is a threshold crossing
   always_comb begin
      activity  = |(tx_logic_in ^ tx_prev) | |(rx_line_in ^ rx_prev);
      keep_fall = keep_prev & ~keep_awake_input;
      keep_rise = ~keep_prev & keep_awake_input;
      both_high = keep_awake_input & power_kill_input;
   end

   // idle timer; kill low or being down pins it expired until a wake cause
   always_comb begin
      next_idle_cnt   = idle_cnt;
      next_timer_done = timer_done;
      if (!power_kill_input || state == stpc_pkg::STPC_DOWN) begin
         next_timer_done = 1'b1;
      end
      if (activity || keep_fall || keep_rise || both_high) begin
         next_idle_cnt   = '0;
         next_timer_done = 1'b0;
      end else if (!timer_done) begin
         if (idle_cnt >= IW'(IDLE_CYC - 1)) begin
            next_timer_done = 1'b1;
         end else begin
            next_idle_cnt = idle_cnt + IW'(1);
         end
      end
   end

   // wake causes: both high, or edge / keep rise or fall with kill released
   always_comb begin
      up_req = power_kill_input & (both_high | ~next_timer_done);
   end

   // power state: down, charge pump settling, active
   always_comb begin
      next_state    = state;
      next_wake_cnt = '0;
      unique case (state)
         stpc_pkg::STPC_DOWN: begin
            if (up_req) next_state = stpc_pkg::STPC_WAKE;
         end
         stpc_pkg::STPC_WAKE: begin
            next_wake_cnt = wake_cnt + WW'(1);
            if (!up_req) next_state = stpc_pkg::STPC_DOWN;
            else if (wake_cnt >= WW'(WAKE_CYC - 1)) next_state = stpc_pkg::STPC_ACTIVE;
         end
         stpc_pkg::STPC_ACTIVE: begin
            if (!up_req) next_state = stpc_pkg::STPC_DOWN;
         end
         default: next_state = stpc_pkg::STPC_DOWN;
      endcase
   end

   always_ff @(posedge sys_clk) begin
      if (!reset_n) begin
         state      <= stpc_pkg::STPC_DOWN;
         idle_cnt   <= '0;
         wake_cnt   <= '0;
         timer_done <= 1'b1;
         tx_prev    <= '0;
         rx_prev    <= '0;
         keep_prev  <= 1'b0;
      end else begin
         state      <= next_state;
         idle_cnt   <= next_idle_cnt;
         wake_cnt   <= next_wake_cnt;
         timer_done <= next_timer_done;
         tx_prev    <= tx_logic_in;
         rx_prev    <= rx_line_in;
         keep_prev  <= keep_awake_input;
      end
   end

   // data path is registered once; one cycle latency, far above line rate
   always_ff @(posedge sys_clk) begin
      if (!reset_n) begin
         tx_line_out  <= '1;
         rx_logic_out <= '1;
      end else begin
         tx_line_out  <= ~tx_logic_in;
         rx_logic_out <= ~rx_line_in;
      end
   end

   // pump runs through wake so the rails settle before drivers enable
   always_comb begin
      charge_pump_en = (state != stpc_pkg::STPC_DOWN);
      tx_line_oe     = {NTX{state == stpc_pkg::STPC_ACTIVE}};
      rx_logic_oe    = '1;
      powered_down   = (state != stpc_pkg::STPC_ACTIVE);
   end

   AST_KILL_DOWN: assert property (@(posedge sys_clk) disable iff (!reset_n)
      !power_kill_input |=> state == stpc_pkg::STPC_DOWN)
      else $error("kill low did not power down");
   AST_BOTH_UP: assert property (@(posedge sys_clk) disable iff (!reset_n)
      (both_high && state == stpc_pkg::STPC_ACTIVE) |=> state == stpc_pkg::STPC_ACTIVE)
      else $error("forced on dropped out");
   AST_TX_HIZ: assert property (@(posedge sys_clk) disable iff (!reset_n)
      state != stpc_pkg::STPC_ACTIVE |-> tx_line_oe == '0)
      else $error("transmitter driving while down");
   AST_RX_DRIVE: assert property (@(posedge sys_clk) disable iff (!reset_n)
      powered_down |-> rx_logic_oe == '1)
      else $error("receiver tristated in powerdown");
   AST_PUMP: assert property (@(posedge sys_clk) disable iff (!reset_n)
      charge_pump_en == (state != stpc_pkg::STPC_DOWN))
      else $error("charge pump state wrong");
   AST_WAKE_TIME: assert property (@(posedge sys_clk) disable iff (!reset_n)
      state == stpc_pkg::STPC_WAKE |-> wake_cnt <= WW'(WAKE_CYC))
      else $error("wake took too long");
   AST_KILL_RELEASE: assert property (@(posedge sys_clk) disable iff (!reset_n)
      (state == stpc_pkg::STPC_DOWN && timer_done && !activity && !keep_awake_input
       && !keep_prev) |=> state == stpc_pkg::STPC_DOWN)
      else $error("woke without a cause");
   AST_TX_INV: assert property (@(posedge sys_clk) disable iff (!reset_n)
      ##1 tx_line_out == ~$past(tx_logic_in))
      else $error("transmitter not inverting");
   AST_RX_INV: assert property (@(posedge sys_clk) disable iff (!reset_n)
      ##1 rx_logic_out == ~$past(rx_line_in))
      else $error("receiver not inverting");
   AST_EDGE_RESTART: assert property (@(posedge sys_clk) disable iff (!reset_n)
      (activity || keep_fall) |=> (idle_cnt == '0 && !timer_done))
      else $error("idle timer not restarted");
   AST_EXPIRED_STAYS: assert property (@(posedge sys_clk) disable iff (!reset_n)
      (state == stpc_pkg::STPC_DOWN && !activity && !keep_rise && !keep_fall && !both_high)
      |=> timer_done)
      else $error("timer cleared while down");
endmodule
`default_nettype wire

// file: tb/stpc_host_model.sv
`timescale 1ns/1ns
`default_nettype none
module stpc_host_model (
   input  wire logic       sys_clk,
   input  wire logic [1:0] mode,
   input  wire logic       line_valid,
   output logic            keep_awake_input,
   output logic            power_kill_input
);
   // mode 0 kill, 1 automatic, 2 forced on, 3 validity flag on both force pins
   initial begin
      keep_awake_input = 1'b0;
      power_kill_input = 1'b0;
   end
   // registered like real host logic, so the flag loop has one cycle of lag
   always @(posedge sys_clk) begin
      keep_awake_input <= (mode == 2'h2) || (mode == 2'h3 && line_valid);
      power_kill_input <= (mode != 2'h0) && (mode != 2'h3 || line_valid);
   end
endmodule
`default_nettype wire

// file: tb/tb.sv
`timescale 1ns/1ns
`default_nettype none
module tb;
   logic       sys_clk = 1'b0;
   logic       reset_n = 1'b0;
   logic [1:0] mode = 2'h0;
   logic [1:0] tx_logic_in = 2'h0;
   logic [1:0] rx_line_in = 2'h0;
   logic [1:0] rx_level_valid = 2'h0;
   wire logic  keep_awake_input, power_kill_input, line_valid, charge_pump_en, powered_down;
   wire logic [1:0] tx_line_out, tx_line_oe, rx_logic_out, rx_logic_oe;
   int         n_errors = 0;
   int         checks = 0;
   int         cyc = 0;

   always #2 sys_clk = ~sys_clk;

   // short idle and wake counts keep the run brief
   stpc_top #(.IDLE_CYC(200), .WAKE_CYC(20)) stpc_top_i (
      .sys_clk(sys_clk), .reset_n(reset_n), .keep_awake_input(keep_awake_input),
      .power_kill_input(power_kill_input), .tx_logic_in(tx_logic_in),
      .tx_line_out(tx_line_out), .tx_line_oe(tx_line_oe), .rx_line_in(rx_line_in),
      .rx_level_valid(rx_level_valid), .rx_logic_out(rx_logic_out),
      .rx_logic_oe(rx_logic_oe), .line_valid(line_valid),
      .charge_pump_en(charge_pump_en), .powered_down(powered_down));

   stpc_host_model stpc_host_model_i (
      .sys_clk(sys_clk), .mode(mode), .line_valid(line_valid),
      .keep_awake_input(keep_awake_input), .power_kill_input(power_kill_input));

   task check(input string what, input logic [3:0] exp, input logic [3:0] got);
      checks++;
      if (exp !== got) begin
         n_errors++;
         $display("unexpected %s: expected %h, seen %h", what, exp, got);
      end
   endtask

   task idle(input int n);
      repeat (n) @(posedge sys_clk);
      #1;
   endtask

   // bounded wait, then compare so a stuck state shows up as a mismatch
   task wait_pd(input logic v, input int lim);
      int i;
      i = 0;
      while (powered_down !== v && i < lim) begin
         @(posedge sys_clk);
         i++;
      end
      #1;
      check("powered_down", {3'h0, v}, {3'h0, powered_down});
   endtask

   task stop_test;
      $display("checks %0d, mismatches %0d", checks, n_errors);
      if (n_errors == 0 && checks > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask

   // whole run is near 9000 cycles
   always @(posedge sys_clk) begin
      cyc++;
      if (cyc == 20000) begin
         n_errors++;
         stop_test();
      end
   end

   initial begin
      idle(3);
      reset_n <= 1'b1;
      idle(2);
      check("rx_logic_oe", 4'h3, {2'h0, rx_logic_oe});
      rx_line_in <= 2'h1;
      idle(30);
      check("powered_down", 4'h1, {3'h0, powered_down});
      check("tx_line_oe", 4'h0, {2'h0, tx_line_oe});
      check("charge_pump_en", 4'h0, {3'h0, charge_pump_en});
      check("rx_logic_out", 4'h2, {2'h0, rx_logic_out});
      $display("test kill done");
      mode <= 2'h1;
      // kill release alone leaves the timer expired; a fresh edge wakes it
      idle(3);
      tx_logic_in <= 2'h2;
      wait_pd(1'b0, 40);
      check("charge_pump_en", 4'h1, {3'h0, charge_pump_en});
      check("tx_line_oe", 4'h3, {2'h0, tx_line_oe});
      tx_logic_in <= 2'h1;
      idle(150);
      check("tx_line_out", 4'h2, {2'h0, tx_line_out});
      check("powered_down", 4'h0, {3'h0, powered_down});
      wait_pd(1'b1, 100);
      idle(50);
      check("powered_down", 4'h1, {3'h0, powered_down});
      $display("test auto done");
      mode <= 2'h0;
      idle(5);
      mode <= 2'h1;
      idle(40);
      check("powered_down", 4'h1, {3'h0, powered_down});
      rx_line_in <= 2'h0;
      wait_pd(1'b0, 40);
      $display("test release done");
      mode <= 2'h2;
      idle(400);
      check("powered_down", 4'h0, {3'h0, powered_down});
      mode <= 2'h1;
      idle(150);
      check("powered_down", 4'h0, {3'h0, powered_down});
      wait_pd(1'b1, 100);
      $display("test forced on done");
      mode <= 2'h3;
      rx_level_valid <= 2'h2;
      idle(245);
      check("line_valid", 4'h0, {3'h0, line_valid});
      idle(10);
      check("line_valid", 4'h1, {3'h0, line_valid});
      wait_pd(1'b0, 40);
      rx_level_valid <= 2'h0;
      idle(7400);
      check("line_valid", 4'h1, {3'h0, line_valid});
      check("powered_down", 4'h0, {3'h0, powered_down});
      idle(150);
      check("line_valid", 4'h0, {3'h0, line_valid});
      wait_pd(1'b1, 10);
      $display("test flag wiring done");
      stop_test();
   end
endmodule
`default_nettype wire
